// File: dv/atr_sink.sv
`timescale 1ns/1ns
`default_nettype none
module atr_sink
  import atr_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      slow,
  input  wire atr_char_s outChar,
  input  wire logic      outValid,
  output logic           outReady
);
  atr_char_s got[$];
  logic      phase_r;

  ////////////////////////////////////////////////////////////////////////////////
  // slow mode takes a character only every other cycle, keeping the formatter busy longer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_r <= 1'b0;
    else
      phase_r <= ~phase_r;
  end
  assign outReady = !slow || phase_r;

  ////////////////////////////////////////////////////////////////////////////////
  // buffer holds any line
  always @(posedge clk)
  begin
    if (outValid && outReady)
      got.push_back(outChar);
  end
endmodule : atr_sink
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "atr_consts.svh"
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        slow = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        waitReq;
  logic [8:0]  oc;
  logic        ov;
  logic        ordy;
  logic [7:0]  expQ[$];
  int          miscompares = 0;
  int          n_checks = 0;

  always #20 clk = ~clk;

  atr_readout i_atr_readout (.clk(clk), .rst_n(rst_n), .ce(1'b1), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(waitReq),
    .outChar(oc), .outValid(ov), .outReady(ordy));
  atr_sink i_atr_sink (.clk(clk), .rst_n(rst_n), .slow(slow), .outChar(oc), .outValid(ov), .outReady(ordy));

  ////////////////////////////////////////////////////////////////////////////////
  // compare and closing report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic hang();
    miscompares++;
    tally_and_finish();
  endtask : hang

  // one bus cycle; request held until waitrequest is sampled low at a rising edge, q takes read data there
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitReq !== 1'b0 && n < 20);
    if (waitReq !== 1'b0)
      hang();
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  ////////////////////////////////////////////////////////////////////////////////
  // memory image: 0 expected, 1 captured, 2 error flags, 3 glitch flags; received when a%5 != 0
  function automatic logic [15:0] img(int a, int k);
    case (k)
      0: return 16'(a * 40503) ^ 16'h5a5a;
      1: return 16'(a * 25173) ^ 16'h0f3c;
      2: return (a % 3 == 0) ? 16'h0000 : 16'h0001 << (a % 16);
      default: return (a % 4 == 0) ? 16'h0000 : 16'h8000 >> (a % 16);
    endcase
  endfunction : img

  function automatic logic [7:0] hc(logic [3:0] v);
    return (v > 4'h9) ? 8'(v) + `ATR_CH_A : 8'(v) + `ATR_CH_0;
  endfunction : hc

  function automatic logic [7:0] sc(int p, int l, int c);
    return 8'h21 + 8'((p * 7 + l * 3 + c) % 90);
  endfunction : sc

  task automatic px(int v, int n);
    for (int i = n - 1; i >= 0; i--)
      expQ.push_back(hc(4'(v >> (4 * i))));
  endtask : px

  task automatic eol();
    expQ.push_back(`ATR_CH_CR);
    expQ.push_back(`ATR_CH_LF);
  endtask : eol

  // expected word string; flag mode drops segments of unreceived words
  task automatic pw(int a, int m, logic dp, logic e, logic g, logic [3:0] seg);
    logic [15:0] v;
    logic [15:0] er;
    logic [15:0] gl;
    logic        dv;
    v = img(a, m == 4 ? 0 : 1);
    er = img(a, 2) & {16{e}};
    gl = img(a, 3) & {16{g}};
    dv = (m == 4) || (a % 5 != 0);
    px(a, dp ? 5 : 4);
    expQ.push_back(`ATR_CH_SP);
    expQ.push_back(`ATR_CH_SP);
    expQ.push_back(a % 2 ? `ATR_CH_X : `ATR_CH_DOT);
    for (int s = 3; s >= 0 && (dv || m != 6); s--)
    begin
      expQ.push_back(`ATR_CH_SP);
      if (seg[s])
        expQ.push_back(m == 6 ? `ATR_CH_0 + {6'h0, |gl[4*s+:4], |er[4*s+:4]} : dv ? hc(v[4*s+:4]) : `ATR_CH_DASH);
      else
        for (int b = 4 * s + 3; b >= 4 * s; b--)
          expQ.push_back(m == 6 ? `ATR_CH_0 + {6'h0, gl[b], er[b]} : dv ? `ATR_CH_0 + {7'h0, v[b]} : `ATR_CH_DASH);
    end
    eol();
  endtask : pw

  // expected error map lines from tsa to the end of memory
  task automatic pm(int transfer_start_address_command, logic dp, logic e, logic g);
    int en;
    for (int s = transfer_start_address_command; s <= (dp ? 16383 : 1023); s = en + 1)
    begin
      en = s - s % 64 + 63;
      px(s, dp ? 5 : 4);
      expQ.push_back(`ATR_CH_SP);
      px(en, dp ? 5 : 4);
      expQ.push_back(`ATR_CH_SP);
      for (int a = s; a <= en; a++)
        expQ.push_back(a % 5 == 0 ? `ATR_CH_DASH : (e && img(a, 2) != 0) || (g && img(a, 3) != 0) ? 8'h31 : 8'h30);
      eol();
    end
  endtask : pm

  task automatic load(int lo, int hi);
    for (int a = lo; a <= hi; a++)
    begin
      bus(1, `ATR_REG_MEMADDR, 32'(a));
      bus(1, `ATR_REG_EXPW, {15'h0, a[0], img(a, 0)});
      bus(1, `ATR_REG_CAPW, {15'h0, 1'(a % 5 != 0), img(a, 1)});
      bus(1, `ATR_REG_FLAGW, {img(a, 3), img(a, 2)});
    end
  endtask : load

  ////////////////////////////////////////////////////////////////////////////////
  // start a transfer, try to move TRANSFER_START_ADDRESS_COMMAND while busy, wait for idle, then judge the stream
  task automatic run(int m, logic dp, logic e, logic g, int transfer_start_address_command, logic [3:0] seg);
    int n;
    n = 0;
    i_atr_sink.got.delete();
    bus(1, `ATR_REG_SEGCODE, {28'h0, seg});
    // the model bit must be set first, since the start address is masked to its depth
    bus(1, `ATR_REG_CTRL, {24'h0, 2'b00, g, e, dp, 3'(m)});
    bus(1, `ATR_REG_TSA, 32'(transfer_start_address_command));
    bus(1, `ATR_REG_CTRL, {24'h0, 2'b10, g, e, dp, 3'(m)});
    bus(1, `ATR_REG_TSA, 32'h0);
    do
    begin
      bus(0, `ATR_REG_CTRL, 32'h0);
      n++;
    end
    while (q[7] !== 1'b0 && n < 9000);
    if (n >= 9000)
      hang();
    bus(0, `ATR_REG_TSA, 32'h0);
    chk(q, 32'(transfer_start_address_command)); // start address kept
    chk(i_atr_sink.got.size(), expQ.size()); // character count
    foreach (expQ[i])
      chk({23'h0, i_atr_sink.got[i]}, {23'h0, expQ[i], expQ[i] == `ATR_CH_LF}); // terminator
    expQ.delete();
  endtask : run

  task automatic wrun(int m, logic dp, logic e, logic g);
    int transfer_start_address_command;
    transfer_start_address_command = dp ? 16380 : 1020;
    for (int a = transfer_start_address_command; a < transfer_start_address_command + 4; a++)
      pw(a, m, dp, e, g, dp ? 4'ha : 4'h5);
    run(m, dp, e, g, transfer_start_address_command, dp ? 4'ha : 4'h5);
  endtask : wrun

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic [31:0] wv[6] = '{32'h0, 32'h7, 32'h2, 32'h0, 32'd27, 32'd25};
    logic [31:0] ev[6] = '{32'h1, 32'h7, 32'h2, 32'h1, 32'h1, 32'd25};
    bus(0, `ATR_REG_CTRL, 32'h0);
    chk(q, 32'h33); // displays on after reset
    bus(0, `ATR_REG_STATUS, 32'h0);
    chk(q, 32'h0); // idle status after reset
    for (int i = 0; i < 6; i++)
    begin
      bus(1, i < 3 ? `ATR_REG_PAGE : `ATR_REG_LINE, wv[i]);
      bus(0, i < 3 ? `ATR_REG_PAGE : `ATR_REG_LINE, 32'h0);
      chk(q, ev[i]); // page and line writes; page 0, line 0 and line 27 are ignored
    end
    bus(0, 6'h3c, 32'h0);
    chk(q, 32'h0); // unmapped read
    $display("test regs done");
  endtask : t_regs

  // page 5 is a decoy; page 2 from line 25 must come out
  task automatic t_dump();
    for (int p = 2; p <= 5; p += 3)
      for (int l = 25; l <= 26; l++)
        for (int c = 0; c < 55; c++)
          bus(1, `ATR_REG_SCRW, {10'h0, 3'(p), 5'(l), 6'(c), sc(p, l, c)});
    for (int l = 25; l <= 26; l++)
    begin
      for (int c = 0; c < 55; c++)
        expQ.push_back(sc(2, l, c));
      eol();
    end
    slow <= 1'b1;
    run(3, 1'b0, 1'b1, 1'b1, 0, 4'h0); // line width
    $display("test dump done");
  endtask : t_dump

  task automatic t_words();
    load(1020, 1023);
    load(16380, 16383);
    for (int m = 4; m <= 5; m++)
      for (int dp = 0; dp <= 1; dp++)
        wrun(m, 1'(dp), 1'b1, 1'b1); // word text
    $display("test words done");
  endtask : t_words

  task automatic t_flags();
    slow <= 1'b0;
    for (int i = 0; i < 4; i++)
      wrun(6, 1'(i), i != 2, i != 1); // flag codes
    $display("test flags done");
  endtask : t_flags

  task automatic t_map();
    load(950, 1019);
    load(16300, 16379);
    pm(950, 1'b0, 1'b1, 1'b1);
    run(7, 1'b0, 1'b1, 1'b1, 950, 4'h0); // line bounds
    pm(16300, 1'b1, 1'b0, 1'b1);
    run(7, 1'b1, 1'b0, 1'b1, 16300, 4'h0); // deep map
    pm(1000, 1'b0, 1'b1, 1'b0);
    run(7, 1'b0, 1'b1, 1'b0, 1000, 4'h0); // glitches hidden
    $display("test map done");
  endtask : t_map

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_dump();
    t_words();
    t_flags();
    t_map();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

// File: verilog/atr_consts.svh
// How it works
// - display dump sends selected page's screen, one string per line from start line.
// - any of the seven pages can be dumped, chosen by the page register.
// - screen is 26 lines; controller usually reads 22, rest is softkey text.
// - every dumped display line is 55 characters wide.
// - start line picks first dumped line; one is the top line.
// - expected-word mode sends addressed expected word, coded per segment.
// - word modes start at transfer start address, one string per next word.
// - mask char X or period at character seven shallow, eight deep.
// - captured-word mode sends addressed captured word, coded per segment.
// - error-flag mode sends codes 0 ok, 1 error, 2 glitch, 3 both.
// - error-flag strings keep address and mask but no data values.
// - error and glitch marks only appear when their display enable is on.
// - with no captured data, error-flag string holds only address and mask.
// - per-bit codes for binary segments, one worst-case code per hex digit.
// - each error-map string covers at most 64 consecutive addresses.
// - error-map line ends at start minus start mod 64 plus 63.
// - first map line starts at transfer start, later ones at multiples of 64.
// - map string carries start, end and one char 0, 1 or dash per address.
// - shallow depth 1024 words is 16 map lines; deep needs 256 lines.
// - map error and glitch marks follow the same display enables.
`ifndef ATR_CONSTS_SVH
`define ATR_CONSTS_SVH
// register byte offsets
`define ATR_REG_CTRL    6'h00
`define ATR_REG_PAGE    6'h04
`define ATR_REG_LINE    6'h08
`define ATR_REG_TSA     6'h0c
`define ATR_REG_SEGCODE 6'h10
`define ATR_REG_MEMADDR 6'h14
`define ATR_REG_EXPW    6'h18
`define ATR_REG_CAPW    6'h1c
`define ATR_REG_FLAGW   6'h20
`define ATR_REG_SCRW    6'h24
`define ATR_REG_STATUS  6'h28
// ctrl fields
`define ATR_CTRL_MODE_LSB 0
`define ATR_CTRL_DEEP     3
`define ATR_CTRL_DISPERR  4
`define ATR_CTRL_DISPGL   5
`define ATR_CTRL_START    7
// reset values
`define ATR_PAGE_RST  3'h1
`define ATR_LINE_RST  5'h01
// geometry
`define ATR_PAGES       3'h7
`define ATR_LINES       5'h1a
`define ATR_COLS        6'h37
`define ATR_DEPTH       16384
`define ATR_LAST_SHAL   16'h03ff
`define ATR_LAST_DEEP   16'h3fff
`define ATR_DIG_SHAL    3'h3
`define ATR_DIG_DEEP    3'h4
// characters
`define ATR_CH_0    8'h30
`define ATR_CH_A    8'h37
`define ATR_CH_SP   8'h20
`define ATR_CH_X    8'h58
`define ATR_CH_DOT  8'h2e
`define ATR_CH_DASH 8'h2d
`define ATR_CH_CR   8'h0d
`define ATR_CH_LF   8'h0a
`endif

// File: verilog/atr_pkg.sv
package atr_pkg;
  typedef enum logic [2:0] {
    ATR_DUMP = 3'h3, ATR_EXPW = 3'h4, ATR_CAPW = 3'h5, ATR_FLAG = 3'h6, ATR_MAP = 3'h7
  } atr_mode_e;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ADDR = 4'h1, S_SEP = 4'h3, S_MASK = 4'h2, S_DATA = 4'h6,
    S_ENDA = 4'h7, S_MAPB = 4'h5, S_LINE = 4'h4, S_CR = 4'hc, S_LF = 4'hd
  } atr_state_e;
  // one character of the talker stream
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } atr_char_s;
endpackage : atr_pkg

// File: verilog/atr_readout.sv
`timescale 1ns/1ns
`default_nettype none
`include "atr_consts.svh"
module atr_readout
  import atr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output atr_char_s        outChar,
  output logic             outValid,
  input  wire logic        outReady
);
  //////////////////////////////////////////////////////////////////////////////
  // storage: each array is sized for the deep model
  logic [15:0] expMem  [0:`ATR_DEPTH-1];
  logic        maskMem [0:`ATR_DEPTH-1];
  logic [15:0] capMem  [0:`ATR_DEPTH-1];
  logic        recvMem [0:`ATR_DEPTH-1];
  logic [15:0] errMem  [0:`ATR_DEPTH-1];
  logic [15:0] glMem   [0:`ATR_DEPTH-1];
  logic [7:0]  scrMem  [0:16383];

  atr_mode_e   mode_r;
  atr_state_e  state_r;
  atr_state_e  sepNext_r;
  logic        deep_r, dispErr_r, dispGl_r, ack_r, sepCnt_r;
  logic [2:0]  page_r, digCnt_r;
  logic [4:0]  line_r, curLine_r;
  logic [5:0]  col_r;
  logic [3:0]  segHex_r;
  logic [1:0]  segIdx_r, bitIdx_r;
  logic [15:0] tsa_r, memAddr_r, curAddr_r, mapPos_r;
  logic        busy, advance, accept, strEnd;
  logic [7:0]  chr;
  logic [15:0] lastAddr, mapEnd, digSrc, word, eBits, gBits;
  logic [19:0] digWide;
  logic [31:0] bitCode;
  logic [3:0]  nib, segE, segG;
  logic [2:0]  nDig;
  logic [1:0]  code;
  logic [13:0] rdAddr;

  function automatic logic [7:0] hexChar(input logic [3:0] v);
    hexChar = (v < 4'ha) ? (`ATR_CH_0 + {4'h0, v}) : (`ATR_CH_A + {4'h0, v});
  endfunction : hexChar

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second edge of a request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign accept          = (avs_read | avs_write) & ack_r;
  assign busy            = (state_r != S_IDLE);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ack_r <= 1'b0;
    else if (ce)
      ack_r <= (avs_read | avs_write) & ~ack_r;

  // read data is captured on the wait cycle so it stands at the accepting edge
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      avs_readdata <= 32'h0;
    else if (ce && avs_read && !ack_r)
      case (avs_address)
        `ATR_REG_CTRL:    avs_readdata <= {24'h0, busy, 1'b0, dispGl_r, dispErr_r, deep_r, mode_r};
        `ATR_REG_PAGE:    avs_readdata <= {29'h0, page_r};
        `ATR_REG_LINE:    avs_readdata <= {27'h0, line_r};
        `ATR_REG_TSA:     avs_readdata <= {16'h0, tsa_r};
        `ATR_REG_SEGCODE: avs_readdata <= {28'h0, segHex_r};
        `ATR_REG_MEMADDR: avs_readdata <= {16'h0, memAddr_r};
        `ATR_REG_STATUS:  avs_readdata <= {4'h0, state_r, 3'h0, curLine_r, curAddr_r};
        default:          avs_readdata <= 32'h0;
      endcase

  // configuration; writes are ignored for fields while a transfer runs
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      mode_r    <= ATR_DUMP;
      deep_r    <= 1'b0;
      dispErr_r <= 1'b1;
      dispGl_r  <= 1'b1;
      page_r    <= `ATR_PAGE_RST;
      line_r    <= `ATR_LINE_RST;
      tsa_r     <= 16'h0;
      segHex_r  <= 4'h0;
      memAddr_r <= 16'h0;
    end
    else if (ce && accept && avs_write && !busy)
      case (avs_address)
        `ATR_REG_CTRL:
        begin
          mode_r    <= atr_mode_e'(avs_writedata[`ATR_CTRL_MODE_LSB +: 3]);
          deep_r    <= avs_writedata[`ATR_CTRL_DEEP];
          dispErr_r <= avs_writedata[`ATR_CTRL_DISPERR];
          dispGl_r  <= avs_writedata[`ATR_CTRL_DISPGL];
        end
        `ATR_REG_PAGE:
          if (avs_writedata[2:0] != 3'h0)
            page_r <= avs_writedata[2:0];
        // start line; writes of 0 or above the 26-line screen are ignored
        `ATR_REG_LINE:
          if (avs_writedata[4:0] != 5'h0 && avs_writedata[4:0] <= `ATR_LINES)
            line_r <= avs_writedata[4:0];
        `ATR_REG_TSA:     tsa_r     <= avs_writedata[15:0] & lastAddr;
        `ATR_REG_SEGCODE: segHex_r  <= avs_writedata[3:0];
        `ATR_REG_MEMADDR: memAddr_r <= avs_writedata[15:0];
        default:          ;
      endcase

  // memory loading through the window at memAddr_r; screen writes carry their own address in avs_writedata
  always_ff @(posedge clk)
    if (ce && accept && avs_write)
      case (avs_address)
        `ATR_REG_EXPW:
        begin
          expMem[memAddr_r[13:0]]  <= avs_writedata[15:0];
          maskMem[memAddr_r[13:0]] <= avs_writedata[16];
        end
        `ATR_REG_CAPW:
        begin
          capMem[memAddr_r[13:0]]  <= avs_writedata[15:0];
          recvMem[memAddr_r[13:0]] <= avs_writedata[16];
        end
        `ATR_REG_FLAGW:
        begin
          errMem[memAddr_r[13:0]] <= avs_writedata[15:0];
          glMem[memAddr_r[13:0]]  <= avs_writedata[31:16];
        end
        `ATR_REG_SCRW:    scrMem[avs_writedata[21:8]] <= avs_writedata[7:0];
        default:          ;
      endcase

  //////////////////////////////////////////////////////////////////////////////
  // character generation
  // depth and address width follow the model
  assign lastAddr = deep_r ? `ATR_LAST_DEEP : `ATR_LAST_SHAL;
  assign nDig     = deep_r ? `ATR_DIG_DEEP : `ATR_DIG_SHAL;
  // line end is start minus start mod 64 plus 63
  assign mapEnd   = {curAddr_r[15:6], 6'h3f};
  assign rdAddr   = (state_r == S_MAPB) ? mapPos_r[13:0] : curAddr_r[13:0];
  assign word     = (mode_r == ATR_EXPW) ? expMem[rdAddr] : capMem[rdAddr];
  // marks gated by the display enables
  assign eBits    = errMem[rdAddr] & {16{dispErr_r}};
  assign gBits    = glMem[rdAddr] & {16{dispGl_r}};
  assign digSrc   = (state_r == S_ENDA) ? mapEnd : curAddr_r;
  // deep addresses print five digits, so the source is padded to twenty bits
  // to keep the top digit select inside the vector
  assign digWide  = {4'h0, digSrc};
  assign nib      = digWide[{digCnt_r, 2'b00} +: 4];

  // per-bit code is error plus twice glitch
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_code
      assign bitCode[2*gi +: 2] = {gBits[gi], eBits[gi]};
    end
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_seg
      assign segE[gi] = |eBits[4*gi +: 4];
      assign segG[gi] = |gBits[4*gi +: 4];
    end
  endgenerate

  // hex segments give one worst-case code per digit
  assign code = segHex_r[segIdx_r] ? {segG[segIdx_r], segE[segIdx_r]}
                                   : bitCode[{segIdx_r, ~bitIdx_r, 1'b0} +: 2];

  always_comb
  begin
    chr = `ATR_CH_SP;
    case (state_r)
      S_ADDR, S_ENDA: chr = hexChar(nib);
      S_MASK:         chr = maskMem[rdAddr] ? `ATR_CH_X : `ATR_CH_DOT;
      S_DATA:
        // flag mode sends codes, never data values
        if (mode_r == ATR_FLAG)
          chr = hexChar({2'b00, code});
        else if (mode_r == ATR_CAPW && !recvMem[rdAddr])
          chr = `ATR_CH_DASH;
        else if (segHex_r[segIdx_r])
          chr = hexChar(word[{segIdx_r, 2'b00} +: 4]);
        else
          chr = word[{segIdx_r, ~bitIdx_r}] ? 8'h31 : `ATR_CH_0;
      S_MAPB:
        if (!recvMem[rdAddr])
          chr = `ATR_CH_DASH;
        else
          chr = (|eBits || |gBits) ? 8'h31 : `ATR_CH_0;
      // screen text of the selected page
      S_LINE:         chr = scrMem[{page_r, curLine_r, col_r}];
      S_CR:           chr = `ATR_CH_CR;
      S_LF:           chr = `ATR_CH_LF;
      default:        chr = `ATR_CH_SP;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // output register, a character leaves per accepted slot
  assign advance = ce && busy && (!outValid || outReady);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      outValid <= 1'b0;
    else if (ce)
    begin
      if (advance)
        outValid <= 1'b1;
      else if (outReady)
        outValid <= 1'b0;
    end

  // line feed carries the end indication
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      outChar <= '0;
    else if (advance)
      outChar <= '{data: chr, last: (state_r == S_LF)};

  //////////////////////////////////////////////////////////////////////////////
  // string sequencer
  assign strEnd = (state_r == S_LF);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      state_r   <= S_IDLE;
      sepNext_r <= S_IDLE;
      sepCnt_r  <= 1'b0;
      digCnt_r  <= 3'h0;
      segIdx_r  <= 2'h0;
      bitIdx_r  <= 2'h0;
      col_r     <= 6'h0;
      curLine_r <= 5'h0;
      curAddr_r <= 16'h0;
      mapPos_r  <= 16'h0;
    end
    else if (ce)
    begin
      if (!busy && accept && avs_write && avs_address == `ATR_REG_CTRL && avs_writedata[`ATR_CTRL_START])
      begin
        // fresh transfer from the programmed start
        curLine_r <= line_r;
        curAddr_r <= tsa_r;
        mapPos_r  <= tsa_r;
        col_r     <= 6'h0;
        digCnt_r  <= nDig;
        case (atr_mode_e'(avs_writedata[2:0]))
          ATR_DUMP:                     state_r <= S_LINE;
          ATR_EXPW, ATR_CAPW, ATR_FLAG: state_r <= S_ADDR;
          ATR_MAP:                      state_r <= S_ADDR;
          default:                      state_r <= S_IDLE;
        endcase
      end
      else if (advance)
        case (state_r)
          S_ADDR, S_ENDA:
            if (digCnt_r == 3'h0)
            begin
              state_r   <= S_SEP;
              sepCnt_r  <= (mode_r != ATR_MAP);
              sepNext_r <= (mode_r != ATR_MAP) ? S_MASK : (state_r == S_ADDR) ? S_ENDA : S_MAPB;
              digCnt_r  <= nDig;
            end
            else
              digCnt_r <= digCnt_r - 3'h1;
          S_SEP:
            if (sepCnt_r)
              sepCnt_r <= 1'b0;
            else
              state_r <= sepNext_r;
          S_MASK:
          begin
            segIdx_r <= 2'h3;
            bitIdx_r <= 2'h0;
            // no captured data leaves only address and mask
            if (mode_r == ATR_FLAG && !recvMem[rdAddr])
              state_r <= S_CR;
            else
            begin
              state_r   <= S_SEP;
              sepNext_r <= S_DATA;
            end
          end
          // segments high to low, grouped by coding
          S_DATA:
            if (segHex_r[segIdx_r] || bitIdx_r == 2'h3)
            begin
              bitIdx_r <= 2'h0;
              segIdx_r <= segIdx_r - 2'h1;
              state_r  <= (segIdx_r == 2'h0) ? S_CR : S_SEP;
            end
            else
              bitIdx_r <= bitIdx_r + 2'h1;
          // at most 64 addresses, stopping at the line end
          S_MAPB:
            if (mapPos_r == mapEnd)
              state_r <= S_CR;
            else
              mapPos_r <= mapPos_r + 16'h1;
          S_LINE:
            if (col_r == `ATR_COLS - 6'h1)
              state_r <= S_CR;
            else
              col_r <= col_r + 6'h1;
          S_CR:    state_r <= S_LF;
          S_LF:
          begin
            col_r <= 6'h0;
            if (mode_r == ATR_DUMP)
            begin
              // the dump runs to the last of 26 lines
              curLine_r <= curLine_r + 5'h1;
              state_r   <= (curLine_r == `ATR_LINES) ? S_IDLE : S_LINE;
            end
            else if (mode_r == ATR_MAP)
            begin
              // next line starts at the following multiple of 64
              curAddr_r <= mapEnd + 16'h1;
              mapPos_r  <= mapEnd + 16'h1;
              state_r   <= (mapEnd >= lastAddr) ? S_IDLE : S_ADDR;
            end
            else
            begin
              curAddr_r <= curAddr_r + 16'h1;
              state_r   <= (curAddr_r == lastAddr) ? S_IDLE : S_ADDR;
            end
          end
          default: state_r <= S_IDLE;
        endcase
    end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_map_len_bound: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == S_MAPB |-> (mapPos_r - curAddr_r) < 16'h40)
    else $error("map line longer than 64 addresses");
  a_map_end_align: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == S_MAPB && advance && mapPos_r == mapEnd) |-> mapPos_r[5:0] == 6'h3f)
    else $error("map line does not end at 64n-1");
  a_map_next_start: assert property (@(posedge clk) disable iff (!rst_n)
    (strEnd && advance && mode_r == ATR_MAP && state_r != S_IDLE && mapEnd < lastAddr)
      |=> curAddr_r[5:0] == 6'h0)
    else $error("later map line not on a 64 boundary");
  a_line_width: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == S_LINE |-> col_r < `ATR_COLS)
    else $error("display column beyond 55");
  a_line_range: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == S_LINE) |-> (curLine_r >= 5'h1 && curLine_r <= `ATR_LINES))
    else $error("display line outside screen");
  a_end_marks_lf: assert property (@(posedge clk) disable iff (!rst_n)
    (outValid && outChar.last) |-> outChar.data == `ATR_CH_LF)
    else $error("end indication without line feed");
  a_cr_then_lf: assert property (@(posedge clk) disable iff (!rst_n)
    (advance && state_r == S_CR) |=> (state_r == S_LF && outChar.data == `ATR_CH_CR))
    else $error("carriage return not followed by line feed");
  a_mask_char: assert property (@(posedge clk) disable iff (!rst_n)
    (advance && state_r == S_MASK) |=> (outChar.data == `ATR_CH_X || outChar.data == `ATR_CH_DOT))
    else $error("mask character wrong");
  a_flag_code: assert property (@(posedge clk) disable iff (!rst_n)
    (advance && state_r == S_DATA && mode_r == ATR_FLAG) |=> (outChar.data >= 8'h30 && outChar.data <= 8'h33))
    else $error("flag code outside 0 to 3");
  a_word_next: assert property (@(posedge clk) disable iff (!rst_n)
    (advance && strEnd && mode_r inside {ATR_EXPW, ATR_CAPW, ATR_FLAG}) |=> curAddr_r == $past(curAddr_r) + 16'h1)
    else $error("word address did not step by one");
  c_dump: cover property (@(posedge clk) advance && state_r == S_LINE && curLine_r == `ATR_LINES);
  c_map_line: cover property (@(posedge clk) advance && state_r == S_MAPB && mapPos_r == mapEnd);
  c_flag_empty: cover property (@(posedge clk) advance && state_r == S_MASK && mode_r == ATR_FLAG && !recvMem[rdAddr]);
endmodule : atr_readout
`default_nettype wire
